/* File: src/dsq_params.svh */
// constants for the linked-item dma sequencer
`ifndef DSQ_PARAMS_SVH
`define DSQ_PARAMS_SVH
`define DSQ_NCH         3
`define DSQ_ADDR_W      9
`define DSQ_CH_SEL_BIT  8
`define DSQ_CH_IDX_HI   6
`define DSQ_CH_IDX_LO   5
`define DSQ_REG_HI      4
// global register offsets
`define DSQ_OFF_INT_STAT 9'h000
`define DSQ_OFF_TC_STAT  9'h004
`define DSQ_OFF_TC_CLR   9'h008
`define DSQ_OFF_ERR_STAT 9'h00C
`define DSQ_OFF_ERR_CLR  9'h010
`define DSQ_OFF_CH_EN    9'h014
`define DSQ_OFF_GLB_CFG  9'h018
// per-channel offsets inside a 32-byte channel window at 9'h100
`define DSQ_OFF_SRC     5'h00
`define DSQ_OFF_DST     5'h04
`define DSQ_OFF_LINK    5'h08
`define DSQ_OFF_CTRL    5'h0C
`define DSQ_OFF_CFG     5'h10
// configuration fields
`define DSQ_CFG_EN      0
`define DSQ_CFG_FC_HI   13
`define DSQ_CFG_FC_LO   11
`define DSQ_CFG_IE      14
`define DSQ_CFG_ITC     15
`define DSQ_CFG_ACT     17
`define DSQ_CFG_HALT    18
`define DSQ_CFG_WMASK   32'h0004_F801
`define DSQ_FC_MEM      3'h0
`define DSQ_FC_PERIPH   2
// control word fields
`define DSQ_CTL_TCI     31
`define DSQ_CTL_DI      27
`define DSQ_CTL_SI      26
`define DSQ_CTL_CNT_HI  11
`define DSQ_CNT_ONE     12'h001
// linked item walk
`define DSQ_LINK_MASK   32'hFFFF_FFFC
`define DSQ_WORD_STEP   32'h0000_0004
`define DSQ_ITEM_LAST   2'h3
`define DSQ_GLB_ON      0
`define DSQ_RST_WORD    32'h0000_0000
`endif

/* File: src/dsq_pkg.sv */
// types for the linked-item dma sequencer
package dsq_pkg;
    typedef enum logic [1:0] {
        DSQ_IDLE  = 2'b00,
        DSQ_READ  = 2'b01,
        DSQ_WRITE = 2'b10,
        DSQ_FETCH = 2'b11
    } dsq_state_e;
    typedef struct packed {
        logic [31:0] src;
        logic [31:0] dst;
        logic [31:0] link;
        logic [31:0] ctrl;
        logic [31:0] cfg;
    } dsq_chan_s;
    typedef struct packed {
        logic        req;
        logic        write;
        logic [31:0] addr;
        logic [31:0] wdata;
    } dsq_mem_req_s;
    typedef struct packed {
        logic        ack;
        logic        err;
        logic [31:0] rdata;
    } dsq_mem_rsp_s;
endpackage : dsq_pkg

/* File: src/dsq_sequencer.sv */
// three-channel linked-item dma sequencer
//
// Implementation choices: strobed register access and the placing of the registers.
`include "dsq_params.svh"
module dsq_sequencer (
    // clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_b,
    // register port
    input  wire logic [`DSQ_ADDR_W-1:0]   reg_addr,
    input  wire logic [31:0]              reg_wdata,
    input  wire logic                     reg_wr,
    input  wire logic                     reg_rd,
    output logic      [31:0]              reg_rdata,
    // memory master port
    output dsq_pkg::dsq_mem_req_s         mem_req,
    input  wire dsq_pkg::dsq_mem_rsp_s    mem_rsp,
    // peripheral request pins
    input  wire logic [`DSQ_NCH-1:0]      periph_req,
    input  wire logic [`DSQ_NCH-1:0]      periph_last,
    output logic      [`DSQ_NCH-1:0]      periph_done,
    // combined interrupt
    output logic                          dma_irq
);

    // ==========================================================
    // state
    dsq_pkg::dsq_chan_s   chan      [`DSQ_NCH];
    dsq_pkg::dsq_chan_s   next_chan [`DSQ_NCH];
    dsq_pkg::dsq_state_e  state;
    dsq_pkg::dsq_state_e  next_state;
    logic [1:0]           cur;
    logic [1:0]           next_cur;
    logic [1:0]           idx;
    logic [1:0]           next_idx;
    logic [31:0]          held;
    logic [31:0]          next_held;
    logic [31:0]          base;
    logic [31:0]          next_base;
    logic                 controller_global_on;
    logic                 next_controller_global_on;
    logic [`DSQ_NCH-1:0]  count_irq_status;
    logic [`DSQ_NCH-1:0]  next_count_irq_status;
    logic [`DSQ_NCH-1:0]  error_irq_status;
    logic [`DSQ_NCH-1:0]  next_error_irq_status;
    logic [`DSQ_NCH-1:0]  next_periph_done;
    logic [31:0]          next_reg_rdata;
    logic [`DSQ_NCH-1:0]  req_meta;
    logic [`DSQ_NCH-1:0]  req_sync;
    logic [`DSQ_NCH-1:0]  last_meta;
    logic [`DSQ_NCH-1:0]  last_sync;
    logic [`DSQ_NCH-1:0]  channel_enabled_status;
    logic [`DSQ_NCH-1:0]  active;

    // ==========================================================
    // peripheral pin synchronisers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            req_meta  <= '0;
            req_sync  <= '0;
            last_meta <= '0;
            last_sync <= '0;
        end else begin
            req_meta  <= periph_req;
            req_sync  <= req_meta;
            last_meta <= periph_last;
            last_sync <= last_meta;
        end
    end

    // ==========================================================
    // per-channel status views
    always_comb begin
        for (int i = 0; i < `DSQ_NCH; i++) begin
            channel_enabled_status[i] = chan[i].cfg[`DSQ_CFG_EN];
            active[i] = chan[i].cfg[`DSQ_CFG_EN] &&
                        ((state != dsq_pkg::DSQ_IDLE && state != dsq_pkg::DSQ_FETCH &&
                          cur == 2'(i)) ||
                         (!chan[i].cfg[`DSQ_CFG_HALT] && req_sync[i] &&
                          chan[i].cfg[`DSQ_CFG_FC_HI:`DSQ_CFG_FC_LO] != `DSQ_FC_MEM));
        end
    end

    // ==========================================================
    // memory master outputs
    always_comb begin
        mem_req.req   = (state != dsq_pkg::DSQ_IDLE);
        mem_req.write = (state == dsq_pkg::DSQ_WRITE);
        mem_req.wdata = held;
        unique case (state)
            dsq_pkg::DSQ_READ:  mem_req.addr = chan[cur].src;
            dsq_pkg::DSQ_WRITE: mem_req.addr = chan[cur].dst;
            dsq_pkg::DSQ_FETCH: mem_req.addr = base + {28'h0, idx, 2'b00};
            dsq_pkg::DSQ_IDLE:  mem_req.addr = `DSQ_RST_WORD;
        endcase
    end

    assign dma_irq = |(count_irq_status | error_irq_status);

    // ==========================================================
    // next-state logic
    always_comb begin
        logic                 found;
        logic [1:0]           pick;
        logic                 item_end;
        logic                 fail;
        logic [2:0]           fc;
        logic [11:0]          cnt;
        logic                 wr_ch;
        logic [4:0]           roff;
        logic [1:0]           rch;
        next_chan                 = chan;
        next_state                = state;
        next_cur                  = cur;
        next_idx                  = idx;
        next_held                 = held;
        next_base                 = base;
        next_controller_global_on = controller_global_on;
        next_count_irq_status     = count_irq_status;
        next_error_irq_status     = error_irq_status;
        next_periph_done          = '0;
        next_reg_rdata            = `DSQ_RST_WORD;
        found                     = 1'b0;
        pick                      = 2'h0;
        item_end                  = 1'b0;
        fail                      = 1'b0;
        fc    = chan[cur].cfg[`DSQ_CFG_FC_HI:`DSQ_CFG_FC_LO];
        cnt   = chan[cur].ctrl[`DSQ_CTL_CNT_HI:0];
        wr_ch = reg_addr[`DSQ_CH_SEL_BIT];
        roff  = reg_addr[`DSQ_REG_HI:0];
        rch   = reg_addr[`DSQ_CH_IDX_HI:`DSQ_CH_IDX_LO];

        // register writes
        if (reg_wr) begin
            if (!wr_ch) begin
                unique case (reg_addr)
                    `DSQ_OFF_TC_CLR:
                        next_count_irq_status = count_irq_status &
                                                ~reg_wdata[`DSQ_NCH-1:0];
                    `DSQ_OFF_ERR_CLR:
                        next_error_irq_status = error_irq_status &
                                                ~reg_wdata[`DSQ_NCH-1:0];
                    `DSQ_OFF_GLB_CFG:
                        next_controller_global_on = reg_wdata[`DSQ_GLB_ON];
                    default: ;
                endcase
            end else if (rch < 2'(`DSQ_NCH)) begin
                unique case (roff)
                    `DSQ_OFF_SRC:  next_chan[rch].src  = reg_wdata;
                    `DSQ_OFF_DST:  next_chan[rch].dst  = reg_wdata;
                    `DSQ_OFF_LINK: next_chan[rch].link = reg_wdata & `DSQ_LINK_MASK;
                    `DSQ_OFF_CTRL: next_chan[rch].ctrl = reg_wdata;
                    `DSQ_OFF_CFG:  next_chan[rch].cfg  = reg_wdata & `DSQ_CFG_WMASK;
                    default: ;
                endcase
            end
        end

        // register reads
        if (reg_rd) begin
            if (!wr_ch) begin
                unique case (reg_addr)
                    `DSQ_OFF_INT_STAT:
                        next_reg_rdata = {29'h0, count_irq_status | error_irq_status};
                    `DSQ_OFF_TC_STAT:  next_reg_rdata = {29'h0, count_irq_status};
                    `DSQ_OFF_ERR_STAT: next_reg_rdata = {29'h0, error_irq_status};
                    `DSQ_OFF_CH_EN:    next_reg_rdata = {29'h0, channel_enabled_status};
                    `DSQ_OFF_GLB_CFG:  next_reg_rdata = {31'h0, controller_global_on};
                    default:           next_reg_rdata = `DSQ_RST_WORD;
                endcase
            end else if (rch < 2'(`DSQ_NCH)) begin
                unique case (roff)
                    `DSQ_OFF_SRC:  next_reg_rdata = chan[rch].src;
                    `DSQ_OFF_DST:  next_reg_rdata = chan[rch].dst;
                    `DSQ_OFF_LINK: next_reg_rdata = chan[rch].link;
                    `DSQ_OFF_CTRL: next_reg_rdata = chan[rch].ctrl;
                    `DSQ_OFF_CFG: begin
                        next_reg_rdata = chan[rch].cfg;
                        next_reg_rdata[`DSQ_CFG_ACT] = active[rch];
                    end
                    default:       next_reg_rdata = `DSQ_RST_WORD;
                endcase
            end
        end

        // transfer engine
        unique case (state)
            dsq_pkg::DSQ_IDLE: begin
                if (controller_global_on) begin
                    for (int i = `DSQ_NCH - 1; i >= 0; i--) begin
                        if (chan[i].cfg[`DSQ_CFG_EN] && !chan[i].cfg[`DSQ_CFG_HALT] &&
                            (chan[i].cfg[`DSQ_CFG_FC_HI:`DSQ_CFG_FC_LO] == `DSQ_FC_MEM ||
                             req_sync[i])) begin
                            found = 1'b1;
                            pick  = 2'(i);
                        end
                    end
                end
                if (found) begin
                    next_cur   = pick;
                    next_state = dsq_pkg::DSQ_READ;
                end
            end
            dsq_pkg::DSQ_READ: begin
                if (mem_rsp.ack) begin
                    if (mem_rsp.err) begin
                        fail = 1'b1;
                    end else begin
                        next_held  = mem_rsp.rdata;
                        next_state = dsq_pkg::DSQ_WRITE;
                    end
                end
            end
            dsq_pkg::DSQ_WRITE: begin
                if (mem_rsp.ack) begin
                    if (mem_rsp.err) begin
                        fail = 1'b1;
                    end else begin
                        if (chan[cur].ctrl[`DSQ_CTL_SI])
                            next_chan[cur].src = chan[cur].src + `DSQ_WORD_STEP;
                        if (chan[cur].ctrl[`DSQ_CTL_DI])
                            next_chan[cur].dst = chan[cur].dst + `DSQ_WORD_STEP;
                        if (fc != `DSQ_FC_MEM)
                            next_periph_done[cur] = 1'b1;
                        if (fc[`DSQ_FC_PERIPH]) begin
                            item_end = last_sync[cur];
                        end else begin
                            next_chan[cur].ctrl[`DSQ_CTL_CNT_HI:0] = cnt - `DSQ_CNT_ONE;
                            item_end = (cnt <= `DSQ_CNT_ONE);
                        end
                        next_state = dsq_pkg::DSQ_IDLE;
                    end
                end
            end
            dsq_pkg::DSQ_FETCH: begin
                if (mem_rsp.ack) begin
                    if (mem_rsp.err) begin
                        fail = 1'b1;
                    end else begin
                        unique case (idx)
                            2'h0: next_chan[cur].src  = mem_rsp.rdata;
                            2'h1: next_chan[cur].dst  = mem_rsp.rdata;
                            2'h2: next_chan[cur].link = mem_rsp.rdata & `DSQ_LINK_MASK;
                            2'h3: next_chan[cur].ctrl = mem_rsp.rdata;
                        endcase
                        next_idx = idx + 2'h1;
                        if (idx == `DSQ_ITEM_LAST)
                            next_state = dsq_pkg::DSQ_IDLE;
                    end
                end
            end
        endcase

        // end of a linked item
        if (item_end) begin
            if (chan[cur].ctrl[`DSQ_CTL_TCI] && chan[cur].cfg[`DSQ_CFG_ITC])
                next_count_irq_status[cur] = 1'b1;
            if (chan[cur].link == `DSQ_RST_WORD) begin
                next_chan[cur].cfg[`DSQ_CFG_EN] = 1'b0;
            end else begin
                next_base  = chan[cur].link & `DSQ_LINK_MASK;
                next_idx   = 2'h0;
                next_state = dsq_pkg::DSQ_FETCH;
            end
        end

        // bus error ends the sequence
        if (fail) begin
            if (chan[cur].cfg[`DSQ_CFG_IE])
                next_error_irq_status[cur] = 1'b1;
            next_chan[cur].cfg[`DSQ_CFG_EN] = 1'b0;
            next_state = dsq_pkg::DSQ_IDLE;
        end
    end

    // ==========================================================
    // registers
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            for (int i = 0; i < `DSQ_NCH; i++) begin
                chan[i] <= '0;
            end
            state                <= dsq_pkg::DSQ_IDLE;
            cur                  <= 2'h0;
            idx                  <= 2'h0;
            held                 <= `DSQ_RST_WORD;
            base                 <= `DSQ_RST_WORD;
            controller_global_on <= 1'b0;
            count_irq_status     <= '0;
            error_irq_status     <= '0;
            periph_done          <= '0;
            reg_rdata            <= `DSQ_RST_WORD;
        end else begin
            for (int i = 0; i < `DSQ_NCH; i++) begin
                chan[i] <= next_chan[i];
            end
            state                <= next_state;
            cur                  <= next_cur;
            idx                  <= next_idx;
            held                 <= next_held;
            base                 <= next_base;
            controller_global_on <= next_controller_global_on;
            count_irq_status     <= next_count_irq_status;
            error_irq_status     <= next_error_irq_status;
            periph_done          <= next_periph_done;
            reg_rdata            <= next_reg_rdata;
        end
    end

endmodule : dsq_sequencer

/* File: sim/dsq_mem_model.sv */
// memory slave model on the sequencer master port
// ==========================================
// memory model
module dsq_mem_model #(
    parameter logic [31:0] ERR_ADDR = 32'h0000_00FC
) (
    // clock and reset
    input wire logic                  clock,
    input wire logic                  rst_b,
    // master side
    input wire dsq_pkg::dsq_mem_req_s mem_req,
    output dsq_pkg::dsq_mem_rsp_s     mem_rsp,
    // answer delay
    input wire logic [3:0]            wait_cycles
);
    logic [31:0] words [64];
    logic [3:0]  cnt;
    logic [31:0] last;
    // item words sit at pointer, +4, +8, +C
    always @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            cnt <= 4'h0;
            last <= 32'h0;
            mem_rsp <= '0;
        end else begin
            mem_rsp.ack <= 1'b0;
            mem_rsp.err <= 1'b0;
            mem_rsp.rdata <= ~last;
            if (mem_req.req && !mem_rsp.ack) begin
                if (cnt < wait_cycles) begin
                    cnt <= cnt + 4'h1;
                end else begin
                    cnt <= 4'h0;
                    mem_rsp.ack <= 1'b1;
                    mem_rsp.err <= (mem_req.addr == ERR_ADDR);
                    if (mem_req.write) begin
                        words[mem_req.addr[7:2]] <= mem_req.wdata;
                    end else begin
                        mem_rsp.rdata <= words[mem_req.addr[7:2]];
                        last <= words[mem_req.addr[7:2]];
                    end
                end
            end
        end
    end
endmodule : dsq_mem_model

/* File: sim/dsq_checker.sv */
// port assertions for the dma sequencer
`include "dsq_params.svh"
// ==========================================
// checker
module dsq_checker (
    // clock and reset
    input wire logic                   clock,
    input wire logic                   rst_b,
    // register port
    input wire logic [`DSQ_ADDR_W-1:0] reg_addr,
    input wire logic                   reg_rd,
    input wire logic                   reg_wr,
    input wire logic [31:0]            reg_rdata,
    // memory port
    input wire dsq_pkg::dsq_mem_req_s  mem_req,
    input wire dsq_pkg::dsq_mem_rsp_s  mem_rsp,
    // peripheral and interrupt
    input wire logic [`DSQ_NCH-1:0]    periph_done,
    input wire logic                   dma_irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rst_b);
    req_hold_a: assert property (mem_req.req && !mem_rsp.ack |=> mem_req.req && $stable(mem_req))
        else $error("request changed before ack");
    rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
        else $error("read data outside read slot");
    link_low_a: assert property (reg_rd && reg_addr[8] && reg_addr[4:0] == 5'h08
        |=> reg_rdata[1:0] == 2'h0)
        else $error("pointer low bits not zero");
    cfg_bits_a: assert property (reg_rd && reg_addr[8] && reg_addr[4:0] == 5'h10
        |=> (reg_rdata & 32'hFFF9_07FE) == 32'h0)
        else $error("unused config bits set");
    no_chan3_a: assert property (reg_rd && reg_addr[8:5] == 4'hB |=> reg_rdata == 32'h0)
        else $error("fourth channel answered");
    err_abort_a: assert property (mem_req.req && mem_rsp.ack && mem_rsp.err && !mem_req.write
        |=> (!(mem_req.req && mem_req.write)) [*3])
        else $error("write after bus error");
    wdata_pair_a: assert property (mem_req.req && !mem_req.write && mem_rsp.ack && !mem_rsp.err
        ##1 mem_req.req && mem_req.write |-> mem_req.wdata == $past(mem_rsp.rdata))
        else $error("write data not the word read");
    done_cause_a: assert property (periph_done != 3'h0 |-> $past(mem_rsp.ack && mem_req.write)
        || $past(mem_rsp.ack && mem_req.write, 2))
        else $error("done without write ack");
    done_pulse_a: assert property (periph_done != 3'h0 |=> periph_done == 3'h0)
        else $error("done longer than a cycle");
    irq_rise_a: assert property ($rose(dma_irq) |-> $past(mem_rsp.ack) || $past(mem_rsp.ack, 2))
        else $error("interrupt without transfer end");
    irq_fall_a: assert property ($fell(dma_irq) |-> $past(reg_wr))
        else $error("interrupt dropped without clear");
endmodule : dsq_checker
bind dsq_sequencer dsq_checker chk (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_rdata(reg_rdata), .mem_req(mem_req),
    .mem_rsp(mem_rsp), .periph_done(periph_done), .dma_irq(dma_irq));

/* File: sim/dsq_testbench.sv */
// self-checking bench for the dma sequencer
`include "dsq_params.svh"
// ==========================================
// bench
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {
        logic [8:0]  a;
        logic [31:0] d;
        logic [31:0] e;
    } dsq_row_s;
    logic                  clock;
    logic                  rst_b;
    logic [8:0]            reg_addr;
    logic [31:0]           reg_wdata;
    logic                  reg_wr;
    logic                  reg_rd;
    logic [31:0]           reg_rdata;
    dsq_pkg::dsq_mem_req_s mem_req;
    dsq_pkg::dsq_mem_rsp_s mem_rsp;
    logic [2:0]            periph_req;
    logic [2:0]            periph_last;
    logic [2:0]            periph_done;
    logic                  dma_irq;
    logic [3:0]            wait_cycles;
    logic [31:0]           v;
    logic [31:0]           wq[$];
    int                    miscompares;
    int                    n_tests;
    int                    n_done;
    dsq_row_s              rows[8];
    dsq_sequencer dut (.clock(clock), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .mem_req(mem_req),
        .mem_rsp(mem_rsp), .periph_req(periph_req), .periph_last(periph_last),
        .periph_done(periph_done), .dma_irq(dma_irq));
    dsq_mem_model mem (.clock(clock), .rst_b(rst_b), .mem_req(mem_req), .mem_rsp(mem_rsp),
        .wait_cycles(wait_cycles));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(negedge clock) begin
        if (periph_done != 3'h0)
            n_done++;
        if (mem_req.req && mem_rsp.ack && mem_req.write)
            wq.push_back(mem_req.addr);
    end
    // ==========================================
    // tasks
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : wrap_up
    task automatic check(string n, logic [31:0] seen, logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", n, exp, seen);
        end
    endtask : check
    task automatic fail(string n);
        miscompares++;
        $display("BAD %s expected done seen timeout", n);
        wrap_up();
    endtask : fail
    task automatic wr(logic [8:0] a, logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
        @(posedge clock);
    endtask : wr
    task automatic rd(logic [8:0] a);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
        @(posedge clock);
    endtask : rd
    task automatic rdc(string n, logic [8:0] a, logic [31:0] e);
        rd(a);
        check(n, v, e);
    endtask : rdc
    task automatic prog(int c, logic [31:0] s, logic [31:0] d, logic [31:0] l,
                        logic [31:0] t, logic [31:0] f);
        logic [8:0] b;
        b = 9'h100 + 9'(c * 32);
        wr(b, s);
        wr(b + 9'h004, d);
        wr(b + 9'h008, l);
        wr(b + 9'h00C, t);
        wr(b + 9'h010, f);
    endtask : prog
    task automatic wait_idle(logic [2:0] m);
        for (int i = 0; i < 300; i++) begin
            rd(`DSQ_OFF_CH_EN);
            if ((v[2:0] & m) == 3'h0)
                return;
        end
        fail("channel idle");
    endtask : wait_idle
    task automatic pword(int ch, logic last);
        int start;
        start = n_done;
        periph_req[ch] <= 1'b1;
        periph_last[ch] <= last;
        for (int i = 0; i < 200 && n_done == start; i++)
            @(posedge clock);
        periph_req[ch] <= 1'b0;
        periph_last[ch] <= 1'b0;
        @(posedge clock);
        if (n_done == start)
            fail("peripheral word");
    endtask : pword
    // ==========================================
    // main sequence
    initial begin
        rst_b = 1'b0;
        reg_addr = 9'h000;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        periph_req = 3'h0;
        periph_last = 3'h0;
        wait_cycles = 4'h0;
        for (int i = 0; i < 64; i++)
            mem.words[i] = 32'hA000_0000 | 32'(i);
        mem.words[16] = 32'h0000_0030;
        mem.words[17] = 32'h0000_0038;
        mem.words[18] = 32'h0000_0000;
        mem.words[19] = 32'h8000_0001;
        rows = '{'{9'h100, 32'h1234_5678, 32'h1234_5678}, '{9'h124, 32'hCAFE_F00D, 32'hCAFE_F00D},
                 '{9'h148, 32'hFFFF_FFFF, 32'hFFFF_FFFC}, '{9'h150, 32'hFFFF_FFFE, 32'h0004_F800},
                 '{9'h160, 32'hFFFF_FFFF, 32'h0}, '{9'h01C, 32'hFFFF_FFFF, 32'h0},
                 '{`DSQ_OFF_TC_CLR, 32'h7, 32'h0}, '{`DSQ_OFF_GLB_CFG, 32'h1, 32'h1}};
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            rdc("row", rows[i].a, rows[i].e);
        end
        $display("register rows done");
        wait_cycles <= 4'h3;
        prog(0, 32'h10, 32'h20, 32'h40, 32'h8C00_0002, 32'h0000_8001);
        wait_idle(3'h1);
        check("copy0", mem.words[8], 32'hA000_0004);
        check("copy1", mem.words[9], 32'hA000_0005);
        check("item", mem.words[14], 32'hA000_000C);
        rdc("tc", `DSQ_OFF_TC_STAT, 32'h1);
        rdc("int", `DSQ_OFF_INT_STAT, 32'h1);
        check("irq", {31'h0, dma_irq}, 32'h1);
        wr(`DSQ_OFF_TC_CLR, 32'h1);
        rdc("tc clr", `DSQ_OFF_TC_STAT, 32'h0);
        check("irq off", {31'h0, dma_irq}, 32'h0);
        $display("linked list done");
        wait_cycles <= 4'h0;
        wq.delete();
        wr(`DSQ_OFF_GLB_CFG, 32'h0);
        for (int c = 2; c >= 0; c--)
            prog(c, 32'h0, 32'hE0 + 32'(4 * (2 - c)), 32'h0, 32'h1, 32'h1);
        check("off", 32'(wq.size()), 32'h0);
        wr(`DSQ_OFF_GLB_CFG, 32'h1);
        wait_idle(3'h7);
        for (int k = 0; k < 3; k++)
            check("order", wq[k], 32'hE8 - 32'(4 * k));
        rdc("mask", `DSQ_OFF_TC_STAT, 32'h0);
        $display("priority done");
        prog(1, 32'hFC, 32'hF0, 32'h0, 32'h1, 32'h0000_4001);
        wait_idle(3'h2);
        rdc("err", `DSQ_OFF_ERR_STAT, 32'h2);
        check("no write", mem.words[60], 32'hA000_003C);
        wr(`DSQ_OFF_ERR_CLR, 32'h2);
        rdc("err clr", `DSQ_OFF_ERR_STAT, 32'h0);
        $display("bus error done");
        prog(1, 32'h4, 32'hD0, 32'h0, 32'h0C00_0002, 32'h0004_0801);
        n_done = 0;
        periph_req[1] <= 1'b1;
        repeat (20) @(posedge clock);
        check("halted", 32'(n_done), 32'h0);
        rdc("en", `DSQ_OFF_CH_EN, 32'h2);
        wr(9'h130, 32'h0000_0801);
        pword(1, 1'b0);
        pword(1, 1'b0);
        wait_idle(3'h2);
        check("p0", mem.words[52], 32'hA000_0001);
        check("p1", mem.words[53], 32'hA000_0002);
        prog(2, 32'h8, 32'hC0, 32'h0, 32'h0000_0005, 32'h0000_2001);
        pword(2, 1'b1);
        wait_idle(3'h4);
        check("pf", mem.words[48], 32'hA000_0002);
        $display("peripheral done");
        rst_b <= 1'b0;
        repeat (10) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rdc("glb rst", `DSQ_OFF_GLB_CFG, 32'h0);
        rdc("cfg rst", 9'h150, 32'h0);
        $display("reset done");
        wrap_up();
    end
endmodule : testbench
